// ===== rtl/drive_status_monitor_bank.v
// Local design decision: the APB slave port.
`include "drive_status_monitor_bank_defines.vh"

module drive_status_monitor_bank #(
    parameter ADDR_W = 10,
    parameter RUN_TICK_CYCLES = `RUN_TIME_UNIT_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // interrupt
    output reg irq,
    // unready causes
    input wire ctrl_circuit_error,
    input wire main_power_error,
    input wire bus_undervoltage,
    input wire soft_start_failed,
    input wire encoder_init_pending,
    input wire ground_short_failed,
    input wire other_unready,
    // run conditions
    input wire servo_fault,
    input wire run_command,
    input wire overtravel_disabled,
    input wire torque_limit_small,
    input wire position_ref_small,
    input wire speed_ref_small,
    input wire torque_ref_small,
    input wire speed_limit_small,
    input wire other_stall,
    // abnormal parameter report
    input wire bad_param_found,
    input wire [7:0] bad_param_group_in,
    input wire [7:0] bad_param_index_in,
    // planning groups
    input wire [15:0] position_plan_group_in,
    input wire [15:0] speed_plan_group_in,
    // raw monitored values
    input wire [15:0] ctrl_sys_stat_in,
    input wire [15:0] ctrl_fault_in,
    input wire [15:0] fabric_sys_stat_in,
    input wire [15:0] fabric_fault_in,
    input wire [15:0] enc_sys_stat_in,
    input wire [15:0] enc_fault_in,
    input wire [15:0] servo_run_mode_in,
    input wire [15:0] ser_enc_stat_in,
    input wire [15:0] ser_enc_fault_in,
    input wire [15:0] offline_inertia_in,
    input wire [15:0] ctrl_supply_in,
    input wire [31:0] phase_u_in,
    input wire [31:0] phase_v_in,
    input wire [15:0] drive_heat_in,
    input wire [15:0] motor_heat_in,
    input wire [31:0] enc_start_pos_in
);

    localparam [31:0] TICK_LAST = RUN_TICK_CYCLES - 1;

    reg [15:0] controller_system_status;
    reg [15:0] controller_fault_state;
    reg [15:0] logic_fabric_system_status;
    reg [15:0] logic_fabric_fault_state;
    reg [15:0] encoder_system_status;
    reg [15:0] encoder_fault_state;
    reg [15:0] bad_param_group;
    reg [15:0] bad_param_index;
    reg [15:0] position_plan_group;
    reg [15:0] speed_plan_group;
    reg [15:0] servo_state;
    reg [15:0] servo_run_mode;
    reg [31:0] servo_run_time;
    reg [15:0] serial_encoder_status_bits;
    reg [15:0] serial_encoder_fault_bits;
    reg [15:0] offline_inertia_tuning;
    reg [15:0] control_supply_voltage;
    reg [31:0] phase_u_current_now;
    reg [31:0] phase_v_current_now;
    reg [15:0] drive_heat_total;
    reg [15:0] motor_heat_total;
    reg [15:0] drive_unready_reasons;
    reg [15:0] motor_stall_reason;
    reg [31:0] encoder_start_position;
    reg [`EVENT_COUNT-1:0] event_status;
    reg [`EVENT_COUNT-1:0] event_mask;
    reg [31:0] tick_count;

    reg [15:0] next_unready;
    reg [15:0] next_stall;
    reg [15:0] next_state;
    reg [31:0] next_prdata;
    reg next_mapped;
    reg next_writable;
    wire [`EVENT_COUNT-1:0] event_hit;
    wire [`EVENT_COUNT-1:0] status_clear;
    wire [7:0] reg_index;
    wire access;
    wire done;
    wire drive_ready;

    assign reg_index = paddr[9:2];
    assign access = psel & penable;
    // one wait state: pready rises in the second access cycle
    assign done = access & pready;
    assign drive_ready = (next_unready == 16'h0000);

    // reason word, one bit per cause
    always @* begin
        next_unready = 16'h0000;
        next_unready[`UNRDY_CTRL_CIRCUIT] = ctrl_circuit_error;
        next_unready[`UNRDY_MAIN_POWER] = main_power_error;
        next_unready[`UNRDY_BUS_UNDERVOLT] = bus_undervoltage;
        next_unready[`UNRDY_SOFT_START] = soft_start_failed;
        next_unready[`UNRDY_ENC_INIT] = encoder_init_pending;
        next_unready[`UNRDY_GROUND_SHORT] = ground_short_failed;
        next_unready[`UNRDY_OTHER] = other_unready;
    end

    // first blocking cause wins, in code order
    always @* begin
        if (!drive_ready || servo_fault) begin
            next_stall = `STALL_NOT_READY;
        end else if (!run_command) begin
            next_stall = `STALL_NO_RUN_CMD;
        end else if (overtravel_disabled) begin
            next_stall = `STALL_OVERTRAVEL;
        end else if (torque_limit_small) begin
            next_stall = `STALL_TRQ_LIMIT;
        end else if (position_ref_small) begin
            next_stall = `STALL_POS_REF;
        end else if (speed_ref_small) begin
            next_stall = `STALL_SPD_REF;
        end else if (torque_ref_small) begin
            next_stall = `STALL_TRQ_REF;
        end else if (speed_limit_small) begin
            next_stall = `STALL_SPD_LIMIT;
        end else if (other_stall) begin
            next_stall = `STALL_OTHER;
        end else begin
            next_stall = `STALL_NONE;
        end
    end

    // fault outranks everything else
    always @* begin
        if (servo_fault) begin
            next_state = `STATE_FAULT;
        end else if (!drive_ready) begin
            next_state = `STATE_NOT_READY;
        end else if (run_command) begin
            next_state = `STATE_RUNNING;
        end else begin
            next_state = `STATE_READY;
        end
    end

    // live sampling of every monitored value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            controller_system_status <= `RESET_HALF;
            controller_fault_state <= `RESET_HALF;
            logic_fabric_system_status <= `RESET_HALF;
            logic_fabric_fault_state <= `RESET_HALF;
            encoder_system_status <= `RESET_HALF;
            encoder_fault_state <= `RESET_HALF;
            servo_run_mode <= `RESET_HALF;
            serial_encoder_status_bits <= `RESET_HALF;
            serial_encoder_fault_bits <= `RESET_HALF;
            offline_inertia_tuning <= `RESET_HALF;
            control_supply_voltage <= `RESET_HALF;
            phase_u_current_now <= `RESET_VALUE;
            phase_v_current_now <= `RESET_VALUE;
            drive_heat_total <= `RESET_HALF;
            motor_heat_total <= `RESET_HALF;
            encoder_start_position <= `RESET_VALUE;
            drive_unready_reasons <= `RESET_HALF;
            motor_stall_reason <= `RESET_HALF;
            servo_state <= `RESET_HALF;
            position_plan_group <= `RESET_HALF;
            speed_plan_group <= `RESET_HALF;
        end else begin
            controller_system_status <= ctrl_sys_stat_in;
            controller_fault_state <= ctrl_fault_in;
            logic_fabric_system_status <= fabric_sys_stat_in;
            logic_fabric_fault_state <= fabric_fault_in;
            encoder_system_status <= enc_sys_stat_in;
            encoder_fault_state <= enc_fault_in;
            servo_run_mode <= servo_run_mode_in;
            serial_encoder_status_bits <= ser_enc_stat_in;
            serial_encoder_fault_bits <= ser_enc_fault_in;
            offline_inertia_tuning <= offline_inertia_in;
            control_supply_voltage <= ctrl_supply_in;
            phase_u_current_now <= phase_u_in;
            phase_v_current_now <= phase_v_in;
            drive_heat_total <= drive_heat_in;
            motor_heat_total <= motor_heat_in;
            encoder_start_position <= enc_start_pos_in;
            drive_unready_reasons <= next_unready;
            motor_stall_reason <= next_stall;
            servo_state <= next_state;
            // out-of-range group numbers saturate rather than wrap
            if (position_plan_group_in > `PLAN_GROUP_MAX) begin
                position_plan_group <= `PLAN_GROUP_MAX;
            end else begin
                position_plan_group <= position_plan_group_in;
            end
            if (speed_plan_group_in > `PLAN_GROUP_MAX) begin
                speed_plan_group <= `PLAN_GROUP_MAX;
            end else begin
                speed_plan_group <= speed_plan_group_in;
            end
        end
    end

    // location held until the next abnormal parameter report
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_param_group <= `RESET_HALF;
            bad_param_index <= `RESET_HALF;
        end else if (bad_param_found) begin
            bad_param_group <= {8'h00, bad_param_group_in};
            bad_param_index <= {8'h00, bad_param_index_in};
        end
    end

    // running time in tenths of a second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count <= `RESET_VALUE;
            servo_run_time <= `RESET_VALUE;
        end else if (servo_state == `STATE_RUNNING) begin
            if (tick_count >= TICK_LAST) begin
                tick_count <= `RESET_VALUE;
                servo_run_time <= servo_run_time + 32'h0000_0001;
            end else begin
                tick_count <= tick_count + 32'h0000_0001;
            end
        end
    end

    // events: new unready cause, fault entry, bad parameter, new stall code
    assign event_hit[`EVT_UNREADY] = |(next_unready & ~drive_unready_reasons);
    assign event_hit[`EVT_FAULT] = (next_state == `STATE_FAULT) &&
        (servo_state != `STATE_FAULT);
    assign event_hit[`EVT_BAD_PARAM] = bad_param_found;
    assign event_hit[`EVT_STALL] = (next_stall != `STALL_NONE) &&
        (next_stall != motor_stall_reason);
    // clear only bits already captured for the reader, so an event landing
    // between capture and completion of the read is not lost
    assign status_clear = {`EVENT_COUNT{done & ~pwrite &
        (reg_index == `IDX_EVENT_STATUS)}} & prdata[`EVENT_COUNT-1:0];

    genvar g;
    generate
        for (g = 0; g < `EVENT_COUNT; g = g + 1) begin : g_event
            // a set in the clearing cycle survives the clear
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    event_status[g] <= 1'b0;
                end else begin
                    event_status[g] <= event_hit[g] | (event_status[g] & ~status_clear[g]);
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_mask <= {`EVENT_COUNT{1'b0}};
            irq <= 1'b0;
        end else begin
            if (done && pwrite && reg_index == `IDX_EVENT_MASK) begin
                event_mask <= pwdata[`EVENT_COUNT-1:0];
            end
            irq <= |(event_status & event_mask);
        end
    end

    // read mux; monitoring words refuse writes with an error
    always @* begin
        next_prdata = 32'h0000_0000;
        next_mapped = 1'b1;
        next_writable = 1'b0;
        case (reg_index)
            `IDX_CTRL_SYS_STAT: next_prdata = {16'h0000, controller_system_status};
            `IDX_CTRL_FAULT: next_prdata = {16'h0000, controller_fault_state};
            `IDX_FABRIC_SYS_STAT: next_prdata = {16'h0000, logic_fabric_system_status};
            `IDX_FABRIC_FAULT: next_prdata = {16'h0000, logic_fabric_fault_state};
            `IDX_ENC_SYS_STAT: next_prdata = {16'h0000, encoder_system_status};
            `IDX_ENC_FAULT: next_prdata = {16'h0000, encoder_fault_state};
            `IDX_BAD_PARAM_GROUP: next_prdata = {16'h0000, bad_param_group};
            `IDX_BAD_PARAM_INDEX: next_prdata = {16'h0000, bad_param_index};
            `IDX_POS_PLAN_GROUP: next_prdata = {16'h0000, position_plan_group};
            `IDX_SPD_PLAN_GROUP: next_prdata = {16'h0000, speed_plan_group};
            `IDX_SERVO_STATE: next_prdata = {16'h0000, servo_state};
            `IDX_SERVO_RUN_MODE: next_prdata = {16'h0000, servo_run_mode};
            `IDX_SERVO_RUN_TIME: next_prdata = servo_run_time;
            `IDX_SER_ENC_STAT: next_prdata = {16'h0000, serial_encoder_status_bits};
            `IDX_SER_ENC_FAULT: next_prdata = {16'h0000, serial_encoder_fault_bits};
            `IDX_OFFLINE_INERTIA: next_prdata = {16'h0000, offline_inertia_tuning};
            `IDX_CTRL_SUPPLY: next_prdata = {16'h0000, control_supply_voltage};
            `IDX_PHASE_U: next_prdata = phase_u_current_now;
            `IDX_PHASE_V: next_prdata = phase_v_current_now;
            `IDX_DRIVE_HEAT: next_prdata = {16'h0000, drive_heat_total};
            `IDX_MOTOR_HEAT: next_prdata = {16'h0000, motor_heat_total};
            `IDX_UNREADY: next_prdata = {16'h0000, drive_unready_reasons};
            `IDX_STALL: next_prdata = {16'h0000, motor_stall_reason};
            `IDX_ENC_START_POS: next_prdata = encoder_start_position;
            `IDX_EVENT_STATUS: next_prdata = {{(32-`EVENT_COUNT){1'b0}}, event_status};
            `IDX_EVENT_MASK: begin
                next_prdata = {{(32-`EVENT_COUNT){1'b0}}, event_mask};
                next_writable = 1'b1;
            end
            default: next_mapped = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RESET_VALUE;
        end else if (access && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? `RESET_VALUE : next_prdata;
            // unaligned or unmapped, or a write to a read-only word
            pslverr <= ~next_mapped | (paddr[1:0] != 2'b00) |
                (pwrite & ~next_writable);
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // drive_status_monitor_bank

// ===== rtl/drive_status_monitor_bank_defines.vh
// How it works
// - the unready reason word holds one bit per cause from bit 0 up: control circuit, main power, bus undervoltage, soft start, encoder init, ground short check, other.
// - the stall reason code reads 0 none, 1 servo not ready, 2 no run command, 3 overtravel, 4 small torque limit.
// - the stall reason code reads 5 small position ref, 6 small speed ref, 7 small torque ref, 8 small speed limit, 9 other.
// - the servo state reads 0 not ready, 1 ready, 2 running, 3 fault.
// - on an abnormal parameter the bank reports its group number, 0 to 255.
// - alongside it the bank reports the parameter's position in its group, 0 to 255.
// - the active position and speed planning group numbers are reported, each limited to 0..16.
`ifndef DRIVE_STATUS_MONITOR_BANK_DEFINES_VH
`define DRIVE_STATUS_MONITOR_BANK_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_CTRL_SYS_STAT 8'h01
`define IDX_CTRL_FAULT 8'h02
`define IDX_FABRIC_SYS_STAT 8'h03
`define IDX_FABRIC_FAULT 8'h04
`define IDX_ENC_SYS_STAT 8'h05
`define IDX_ENC_FAULT 8'h06
`define IDX_BAD_PARAM_GROUP 8'h07
`define IDX_BAD_PARAM_INDEX 8'h08
`define IDX_POS_PLAN_GROUP 8'h09
`define IDX_SPD_PLAN_GROUP 8'h0a
`define IDX_SERVO_STATE 8'h0b
`define IDX_SERVO_RUN_MODE 8'h0c
`define IDX_SERVO_RUN_TIME 8'h0d
`define IDX_SER_ENC_STAT 8'h11
`define IDX_SER_ENC_FAULT 8'h12
`define IDX_OFFLINE_INERTIA 8'h35
`define IDX_CTRL_SUPPLY 8'h36
`define IDX_PHASE_U 8'h37
`define IDX_PHASE_V 8'h39
`define IDX_DRIVE_HEAT 8'h3f
`define IDX_MOTOR_HEAT 8'h40
`define IDX_UNREADY 8'h43
`define IDX_STALL 8'h44
`define IDX_ENC_START_POS 8'h51
`define IDX_EVENT_STATUS 8'h60
`define IDX_EVENT_MASK 8'h61

`define RESET_VALUE 32'h0000_0000
`define RESET_HALF 16'h0000
`define EVENT_COUNT 4
`define EVT_UNREADY 0
`define EVT_FAULT 1
`define EVT_BAD_PARAM 2
`define EVT_STALL 3

// unready reason bit positions
`define UNRDY_CTRL_CIRCUIT 0
`define UNRDY_MAIN_POWER 1
`define UNRDY_BUS_UNDERVOLT 2
`define UNRDY_SOFT_START 3
`define UNRDY_ENC_INIT 4
`define UNRDY_GROUND_SHORT 5
`define UNRDY_OTHER 6

// stall reason codes
`define STALL_NONE 16'h0000
`define STALL_NOT_READY 16'h0001
`define STALL_NO_RUN_CMD 16'h0002
`define STALL_OVERTRAVEL 16'h0003
`define STALL_TRQ_LIMIT 16'h0004
`define STALL_POS_REF 16'h0005
`define STALL_SPD_REF 16'h0006
`define STALL_TRQ_REF 16'h0007
`define STALL_SPD_LIMIT 16'h0008
`define STALL_OTHER 16'h0009

// servo state codes
`define STATE_NOT_READY 16'h0000
`define STATE_READY 16'h0001
`define STATE_RUNNING 16'h0002
`define STATE_FAULT 16'h0003

`define PLAN_GROUP_MAX 16'h0010
`define CLK_PERIOD_NS 10
`define RUN_TIME_UNIT_NS 100000000

`endif

// ===== tb/drive_status_monitor_bank_chk.sv
`include "drive_status_monitor_bank_defines.vh"

module drive_status_monitor_bank_chk #(
    parameter ADDR_W = 10
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // monitored causes
    input wire ctrl_circuit_error,
    input wire main_power_error,
    input wire bus_undervoltage,
    input wire soft_start_failed,
    input wire encoder_init_pending,
    input wire ground_short_failed,
    input wire other_unready,
    input wire servo_fault,
    input wire [15:0] position_plan_group_in
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
    wire rd = psel && penable && pready && !pwrite && paddr[1:0] == 2'b00;
    wire [6:0] causes = {other_unready, ground_short_failed, encoder_init_pending,
        soft_start_failed, bus_undervoltage, main_power_error, ctrl_circuit_error};
    // register then read mux: inputs show two edges before the answer
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("answer not one cycle after access");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_WR_REFUSED: assert property (pready && pwrite && idx != `IDX_EVENT_MASK |-> pslverr)
        else $error("write to monitoring register not refused");
    AST_UNREADY: assert property (rd && idx == `IDX_UNREADY
        |-> prdata == {25'h0, $past(causes, 2)})
        else $error("unready word differs from causes");
    AST_STALL_NR: assert property (rd && idx == `IDX_STALL
        && $past(servo_fault, 2) |-> prdata == 32'h1)
        else $error("stall code not 1 on fault");
    AST_STALL_RANGE: assert property (rd && idx == `IDX_STALL |-> prdata <= 32'h9)
        else $error("stall code out of range");
    AST_STATE: assert property (rd && idx == `IDX_SERVO_STATE
        |-> prdata <= 32'h3 && (!$past(servo_fault, 2) || prdata == 32'h3))
        else $error("servo state wrong");
    AST_PLAN: assert property (rd && idx == `IDX_POS_PLAN_GROUP
        |-> prdata == ($past(position_plan_group_in, 2) > `PLAN_GROUP_MAX
        ? {16'h0, `PLAN_GROUP_MAX} : {16'h0, $past(position_plan_group_in, 2)}))
        else $error("plan group not saturated copy");
    AST_BADP_RANGE: assert property (rd && (idx == `IDX_BAD_PARAM_GROUP
        || idx == `IDX_BAD_PARAM_INDEX) |-> prdata[31:8] == 24'h0)
        else $error("bad parameter report above 255");
endmodule // drive_status_monitor_bank_chk

bind drive_status_monitor_bank drive_status_monitor_bank_chk #(.ADDR_W(ADDR_W)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_circuit_error(ctrl_circuit_error), .main_power_error(main_power_error),
    .bus_undervoltage(bus_undervoltage), .soft_start_failed(soft_start_failed),
    .encoder_init_pending(encoder_init_pending), .ground_short_failed(ground_short_failed),
    .other_unready(other_unready), .servo_fault(servo_fault),
    .position_plan_group_in(position_plan_group_in));

// ===== tb/tb_drive_status_monitor_bank.sv
`include "drive_status_monitor_bank_defines.vh"

module tb_drive_status_monitor_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault = 0, run = 0, bpf = 0;
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0, r, t0;
    logic e;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    logic [6:0] unr = '0, cnd = '0;
    logic [7:0] bpg = '0, bpi = '0;
    logic [15:0] ppg = '0, spg = '0, rb = '0, pv [4] = '{16'h0, 16'h10, 16'h11, 16'hffff};
    logic [21:0] rows [17];
    logic [7:0] ri [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0c, 8'h11,
        8'h12, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3f, 8'h40, 8'h51};
    int fails = 0, check_count = 0, n;

    always #5 pclk = ~pclk;

    drive_status_monitor_bank #(.RUN_TICK_CYCLES(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .ctrl_circuit_error(unr[0]), .main_power_error(unr[1]),
        .bus_undervoltage(unr[2]), .soft_start_failed(unr[3]), .encoder_init_pending(unr[4]),
        .ground_short_failed(unr[5]), .other_unready(unr[6]), .servo_fault(fault),
        .run_command(run), .overtravel_disabled(cnd[0]), .torque_limit_small(cnd[1]),
        .position_ref_small(cnd[2]), .speed_ref_small(cnd[3]), .torque_ref_small(cnd[4]),
        .speed_limit_small(cnd[5]), .other_stall(cnd[6]), .bad_param_found(bpf),
        .bad_param_group_in(bpg), .bad_param_index_in(bpi), .position_plan_group_in(ppg),
        .speed_plan_group_in(spg), .ctrl_sys_stat_in(rb | 16'h01), .ctrl_fault_in(rb | 16'h02),
        .fabric_sys_stat_in(rb | 16'h03), .fabric_fault_in(rb | 16'h04),
        .enc_sys_stat_in(rb | 16'h05), .enc_fault_in(rb | 16'h06),
        .servo_run_mode_in(rb | 16'h0c), .ser_enc_stat_in(rb | 16'h11),
        .ser_enc_fault_in(rb | 16'h12), .offline_inertia_in(rb | 16'h35),
        .ctrl_supply_in(rb | 16'h36), .phase_u_in({rb, rb | 16'h37}),
        .phase_v_in({rb, rb | 16'h39}), .drive_heat_in(rb | 16'h3f),
        .motor_heat_in(rb | 16'h40), .enc_start_pos_in({rb, rb | 16'h51}));

    task end_of_test;
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // holds the request until ready is seen high at an edge
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                end_of_test;
            end
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rd(input logic [7:0] i, input logic [31:0] exp);
        apb(0, {i, 2'b00}, 32'h0);
        chk(r, exp);
        chk({31'h0, e}, 32'h0);
    endtask

    task bad(input logic w, input logic [9:0] a);
        apb(w, a, 32'hffff_ffff);
        chk({31'h0, e}, 32'h1);
    endtask

    task pulse;
        bpf <= 1;
        @(posedge pclk);
        bpf <= 0;
    endtask

    initial begin
        for (int i = 0; i < 7; i++) begin
            rows[i] = {2'b01, 7'h01 << i, 7'h00, 2'd0, 4'd1};
            rows[9 + i] = {2'b01, 7'h00, 7'h7f << i, 2'd2, 4'(i + 3)};
        end
        rows[7] = {2'b11, 7'h7f, 7'h00, 2'd3, 4'd1};
        rows[8] = {2'b00, 14'h0, 2'd1, 4'd2};
        rows[16] = {2'b01, 14'h0, 2'd2, 4'd0};
        repeat (6) @(posedge pclk);
        chk({29'h0, pready, pslverr, irq}, 32'h0);
        presetn <= 1;
        rd(`IDX_EVENT_MASK, 32'h0);
        rd(`IDX_SERVO_RUN_TIME, 32'h0);
        rd(`IDX_BAD_PARAM_GROUP, 32'h0);
        foreach (rows[k]) begin
            {fault, run, unr, cnd} <= rows[k][21:6];
            rd(`IDX_SERVO_STATE, rows[k][5:4]);
            rd(`IDX_STALL, rows[k][3:0]);
            rd(`IDX_UNREADY, unr);
        end
        for (int b = 0; b < 2; b++) begin
            rb <= b ? 16'ha500 : 16'h5a00;
            // let the new base settle before it feeds the expectations
            @(posedge pclk);
            foreach (ri[j])
                rd(ri[j], (ri[j] == 8'h37 || ri[j] == 8'h39 || ri[j] == 8'h51)
                    ? {rb, rb | ri[j]} : rb | ri[j]);
        end
        foreach (pv[k]) begin
            ppg <= pv[k];
            spg <= ~pv[k];
            rd(`IDX_POS_PLAN_GROUP, pv[k] > 16'h10 ? 16'h10 : pv[k]);
            rd(`IDX_SPD_PLAN_GROUP, ~pv[k] > 16'h10 ? 16'h10 : 16'(~pv[k]));
        end
        bpg <= 8'hff;
        bpi <= 8'h56;
        pulse;
        bpg <= 8'h12;
        bpi <= 8'h34;
        rd(`IDX_BAD_PARAM_GROUP, 32'hff);
        rd(`IDX_BAD_PARAM_INDEX, 32'h56);
        bad(1, {`IDX_SERVO_STATE, 2'b00});
        rd(`IDX_SERVO_STATE, 32'h2);
        bad(1, {`IDX_UNREADY, 2'b00});
        bad(0, 10'h2d);
        // unaligned read is refused but still carries the word of its index
        chk(r, 32'h2);
        bad(0, 10'h0e0);
        chk(r, 32'h0);
        apb(0, {`IDX_SERVO_RUN_TIME, 2'b00}, 32'h0);
        t0 = r;
        repeat (100) @(posedge pclk);
        apb(0, {`IDX_SERVO_RUN_TIME, 2'b00}, 32'h0);
        chk({31'h0, r - t0 >= 9 && r - t0 <= 12}, 32'h1);
        run <= 0;
        apb(0, {`IDX_SERVO_RUN_TIME, 2'b00}, 32'h0);
        t0 = r;
        repeat (50) @(posedge pclk);
        rd(`IDX_SERVO_RUN_TIME, t0);
        apb(1, 10'h184, 32'h4);
        rd(`IDX_EVENT_MASK, 32'h4);
        apb(0, 10'h180, 32'h0);
        pulse;
        for (n = 0; n < 5 && irq !== 1'b1; n++)
            @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(0, 10'h180, 32'h0);
        chk({31'h0, r[2]}, 32'h1);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1, 10'h184, 32'h0);
        pulse;
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1, 10'h184, 32'hf);
        presetn <= 0;
        @(posedge pclk);
        chk({30'h0, pready, irq}, 32'h0);
        presetn <= 1;
        rd(`IDX_EVENT_MASK, 32'h0);
        end_of_test;
    end
endmodule // tb_drive_status_monitor_bank
